// >>> core/bgpio_defines.svh
`ifndef BGPIO_DEFINES_SVH
`define BGPIO_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BGPIO_OFF_DIR 4'hA
`define BGPIO_OFF_LEVEL 4'hB
`define BGPIO_OFF_IRQ_EN 4'hC
`define BGPIO_OFF_CTRL 4'hE
// ----------------------------------------
// Reset values
// ----------------------------------------
`define BGPIO_RST_DIR 8'h00
`define BGPIO_RST_LEVEL 8'hFF
`define BGPIO_RST_IRQ_EN 8'h00
`define BGPIO_RST_CTRL 8'h00
// ----------------------------------------
// Control fields
// ----------------------------------------
`define BGPIO_CTRL_LATCH 0
`define BGPIO_CTRL_MODEM_HI 1
`define BGPIO_CTRL_MODEM_LO 2
`define BGPIO_CTRL_SWRST 3
`define BGPIO_CTRL_RW_MASK 8'h07
`define BGPIO_MODEM_OE 8'h22
`define BGPIO_SWRST_CYCLES 4'h4
`endif

// >>> core/bgpio_pkg.sv
package bgpio_pkg;
  typedef enum logic [1:0] {BGPIO_RUN, BGPIO_SWRST} bgpio_rst_state_t;
endpackage : bgpio_pkg

// >>> core/bgpio_port.sv
`timescale 1ns/1ns
`include "bgpio_defines.svh"
// Behaviour
// - Reading the pin level register returns present level of each pin, or its latched level while a latched interrupt is pending.
// - Writing pin level drives output-configured pins outside modem nibbles; input pins unaffected.
// - One interrupt enable bit per pin; 1 allows on input-configured pins (output pins never interrupt), 0 blocks.
// - Enable bits have no effect on a nibble assigned to modem signals.
// - Control bit 3 written 1 resets the device, then clears itself.
// - Control bit 2 gives lower nibble to second channel modem lines.
// - Control bit 1 gives upper nibble to first channel modem lines.
// - Latching off: interrupt clears if input reverts before level read.
// - Latching on: interrupt and level bit held until level register read.
// - Pin registers shared; software reset resets all channels together.
// - After reset level reads FF, enable and control read zero.
// - Control bits 7 to 4 are reserved, read-only zero.
// - Direction register: 0 input, 1 output; resets to zero.
module bgpio_port #(
  parameter int PINS = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_out,
  input wire logic terminal_ready_first_in,
  input wire logic terminal_ready_second_in,
  output logic ring_indicator_first_out,
  output logic carrier_detect_first_out,
  output logic set_ready_first_out,
  output logic ring_indicator_second_out,
  output logic carrier_detect_second_out,
  output logic set_ready_second_out,
  output logic modem_first_sel_out,
  output logic modem_second_sel_out,
  output logic soft_reset_out,
  output logic pin_irq_out
);
  if (PINS != 8) begin : g_pins_check
    $error("bgpio_port serves exactly eight pins");
  end

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;
  logic [PINS-1:0] seen_q;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= `BGPIO_RST_LEVEL;
      sync2_q <= `BGPIO_RST_LEVEL;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // Software reset sequencer
  // ----------------------------------------
  bgpio_pkg::bgpio_rst_state_t rst_state_q;
  logic [3:0] rst_cnt_q;
  logic soft_rst;
  logic wr_ctrl;
  assign wr_ctrl = reg_wr_in && reg_addr_in == `BGPIO_OFF_CTRL;
  assign soft_rst = rst_state_q == bgpio_pkg::BGPIO_SWRST;
  // Held several cycles so every channel sees it, then the bit drops alone
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rst_state_q <= bgpio_pkg::BGPIO_RUN;
      rst_cnt_q <= 4'h0;
    end else begin
      unique case (rst_state_q)
        bgpio_pkg::BGPIO_RUN: begin
          if (wr_ctrl && reg_wdata_in[`BGPIO_CTRL_SWRST]) begin
            rst_state_q <= bgpio_pkg::BGPIO_SWRST;
            rst_cnt_q <= `BGPIO_SWRST_CYCLES;
          end
        end
        bgpio_pkg::BGPIO_SWRST: begin
          rst_cnt_q <= rst_cnt_q - 4'h1;
          if (rst_cnt_q == 4'h1) begin
            rst_state_q <= bgpio_pkg::BGPIO_RUN;
          end
        end
        default: rst_state_q <= bgpio_pkg::BGPIO_RUN;
      endcase
    end
  end
  assign soft_reset_out = soft_rst;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] dir_q;
  logic [7:0] out_q;
  logic [7:0] irq_en_q;
  logic [2:0] ctrl_q;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dir_q <= `BGPIO_RST_DIR;
      out_q <= `BGPIO_RST_LEVEL;
      irq_en_q <= `BGPIO_RST_IRQ_EN;
      ctrl_q <= 3'h0;
    end else if (soft_rst) begin
      dir_q <= `BGPIO_RST_DIR;
      out_q <= `BGPIO_RST_LEVEL;
      irq_en_q <= `BGPIO_RST_IRQ_EN;
      ctrl_q <= 3'h0;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `BGPIO_OFF_DIR: dir_q <= reg_wdata_in;
        `BGPIO_OFF_LEVEL: out_q <= reg_wdata_in;
        `BGPIO_OFF_IRQ_EN: irq_en_q <= reg_wdata_in;
        `BGPIO_OFF_CTRL: ctrl_q <= reg_wdata_in[2:0];
        default: ;
      endcase
    end
  end

  logic modem_hi;
  logic modem_lo;
  logic [7:0] gpio_mask;
  assign modem_hi = ctrl_q[`BGPIO_CTRL_MODEM_HI];
  assign modem_lo = ctrl_q[`BGPIO_CTRL_MODEM_LO];
  assign gpio_mask = {{4{~modem_hi}}, {4{~modem_lo}}};
  assign modem_first_sel_out = modem_hi;
  assign modem_second_sel_out = modem_lo;

  // ----------------------------------------
  // Pin drive and modem nibbles
  // ----------------------------------------
  // Nibble order per channel: ring, carrier, terminal ready (out), set ready
  logic [7:0] modem_oe;
  logic [7:0] modem_out;
  assign modem_oe = `BGPIO_MODEM_OE;
  assign modem_out = {2'h0, terminal_ready_first_in, 3'h0, terminal_ready_second_in, 1'h0};
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (gpio_mask[i]) begin
        pin_oe_out[i] = dir_q[i];
        pin_out[i] = out_q[i] & dir_q[i];
      end else begin
        pin_oe_out[i] = modem_oe[i];
        pin_out[i] = modem_oe[i] & modem_out[i];
      end
    end
  end
  assign ring_indicator_first_out = modem_hi ? sync2_q[7] : 1'b1;
  assign carrier_detect_first_out = modem_hi ? sync2_q[6] : 1'b1;
  assign set_ready_first_out = modem_hi ? sync2_q[4] : 1'b1;
  assign ring_indicator_second_out = modem_lo ? sync2_q[3] : 1'b1;
  assign carrier_detect_second_out = modem_lo ? sync2_q[2] : 1'b1;
  assign set_ready_second_out = modem_lo ? sync2_q[0] : 1'b1;

  // ----------------------------------------
  // Change detect, latching and interrupt
  // ----------------------------------------
  logic rd_level;
  logic [7:0] pend_q;
  logic [7:0] latch_q;
  logic [7:0] watch;
  logic latch_on;
  assign rd_level = reg_rd_in && reg_addr_in == `BGPIO_OFF_LEVEL;
  assign latch_on = ctrl_q[`BGPIO_CTRL_LATCH];
  assign watch = irq_en_q & gpio_mask & ~dir_q;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic changed;
      assign changed = sync2_q[g] != seen_q[g];
      // A read clear wins over a new edge in that cycle; with latching on, seen_q takes latch_q so the edge sets pend_q again next cycle
      always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
          pend_q[g] <= 1'b0;
          latch_q[g] <= 1'b1;
          seen_q[g] <= 1'b1;
        end else if (soft_rst) begin
          pend_q[g] <= 1'b0;
          seen_q[g] <= sync2_q[g];
          latch_q[g] <= sync2_q[g];
        end else if (!watch[g]) begin
          pend_q[g] <= 1'b0;
          seen_q[g] <= sync2_q[g];
          latch_q[g] <= sync2_q[g];
        end else if (pend_q[g] && latch_on) begin
          if (rd_level) begin
            pend_q[g] <= 1'b0;
            seen_q[g] <= latch_q[g];
          end
        end else if (pend_q[g]) begin
          if (!changed) begin
            pend_q[g] <= 1'b0;
          end else if (rd_level) begin
            pend_q[g] <= 1'b0;
            seen_q[g] <= sync2_q[g];
          end
        end else if (changed) begin
          pend_q[g] <= 1'b1;
          latch_q[g] <= sync2_q[g];
        end
      end
    end
  endgenerate
  assign pin_irq_out = |pend_q;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] level_view;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level_view[i] = (pend_q[i] && latch_on) ? latch_q[i] : sync2_q[i];
    end
  end
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      unique case (reg_addr_in)
        `BGPIO_OFF_DIR: reg_rdata_out <= dir_q;
        `BGPIO_OFF_LEVEL: reg_rdata_out <= level_view;
        `BGPIO_OFF_IRQ_EN: reg_rdata_out <= irq_en_q;
        `BGPIO_OFF_CTRL: reg_rdata_out <= {4'h0, soft_rst, ctrl_q};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule : bgpio_port

// >>> testbench/bgpio_port_props.sv
`timescale 1ns/1ns
module bgpio_port_props #(
  parameter int PINS = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_out,
  input wire logic terminal_ready_first_in,
  input wire logic terminal_ready_second_in,
  input wire logic ring_indicator_first_out,
  input wire logic carrier_detect_first_out,
  input wire logic set_ready_first_out,
  input wire logic ring_indicator_second_out,
  input wire logic carrier_detect_second_out,
  input wire logic set_ready_second_out,
  input wire logic modem_first_sel_out,
  input wire logic modem_second_sel_out,
  input wire logic soft_reset_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire ctrl_wr = reg_wr_in && reg_addr_in == 4'hE;
  a_swrst_len: assert property ($rose(soft_reset_out) |-> soft_reset_out [*4] ##1 !soft_reset_out)
    else $error("soft reset length wrong");
  a_swrst_cause: assert property ($rose(soft_reset_out) |-> $past(ctrl_wr && reg_wdata_in[3]))
    else $error("soft reset without control write");
  a_swrst_clear: assert property ($fell(soft_reset_out) |-> !modem_first_sel_out && !modem_second_sel_out && pin_oe_out == '0)
    else $error("soft reset left state behind");
  a_ctrl_rsvd: assert property ($past(reg_addr_in) == 4'hE |-> reg_rdata_out[7:4] == 4'h0)
    else $error("control reserved bits not zero");
  a_first_idle: assert property (!modem_first_sel_out |-> {ring_indicator_first_out, carrier_detect_first_out, set_ready_first_out} == 3'h7)
    else $error("first channel modem lines active in pin mode");
  a_first_map: assert property (modem_first_sel_out |-> pin_oe_out[7:4] == 4'h2 && pin_out[5] == terminal_ready_first_in)
    else $error("first channel nibble mapping wrong");
  a_second_map: assert property (modem_second_sel_out |-> pin_oe_out[3:0] == 4'h2 && pin_out[1] == terminal_ready_second_in)
    else $error("second channel nibble mapping wrong");
  a_sel_cause: assert property ($rose(modem_first_sel_out) |-> $past(ctrl_wr && reg_wdata_in[1]))
    else $error("modem select without control write");
  a_out_gated: assert property (!modem_first_sel_out && !modem_second_sel_out |-> (pin_out & ~pin_oe_out) == '0)
    else $error("input pin driven high");
endmodule : bgpio_port_props
bind bgpio_port bgpio_port_props #(.PINS(PINS)) u_props (.*);

// >>> testbench/bgpio_pin_model.sv
`timescale 1ns/1ns
// Pins the device drives win; the rest follow the attached external levels
module bgpio_pin_model (
  input wire logic [7:0] drv_in,
  input wire logic [7:0] drv_oe_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] wire_out
);
  assign wire_out = (drv_oe_in & drv_in) | (~drv_oe_in & ext_in);
endmodule : bgpio_pin_model

// >>> testbench/tb_bridge_gpio_modem_pin_port.sv
`timescale 1ns/1ns
module tb_bridge_gpio_modem_pin_port;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tr1 = 1'b0, tr2 = 1'b0;
  logic r1, c1, s1, r2, c2, s2, m1, m2, sr, irq;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, ext = 8'hFF, rdv, po, oe, pw;
  int num_errors = 0, checks_done = 0;
  always #2 clk = ~clk;
  bgpio_port dut (.ref_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdv), .pin_in(pw), .pin_out(po),
    .pin_oe_out(oe), .terminal_ready_first_in(tr1), .terminal_ready_second_in(tr2),
    .ring_indicator_first_out(r1), .carrier_detect_first_out(c1), .set_ready_first_out(s1),
    .ring_indicator_second_out(r2), .carrier_detect_second_out(c2),
    .set_ready_second_out(s2), .modem_first_sel_out(m1), .modem_second_sel_out(m2),
    .soft_reset_out(sr), .pin_irq_out(irq));
  bgpio_pin_model ext_pins (.drv_in(po), .drv_oe_in(oe), .ext_in(ext), .wire_out(pw));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdv, e);
  endtask : rchk
  task automatic pins(input logic [7:0] v);
    @(posedge clk);
    ext <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask : pins
  task automatic finish_test;
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(4'hB, 8'hFF);
    rchk(4'hC, 8'h00);
    rchk(4'hE, 8'h00);
    rchk(4'hA, 8'h00);
    rchk(4'h5, 8'h00);
    wreg(4'hE, 8'hF7);
    rchk(4'hE, 8'h07);
    wreg(4'hE, 8'h00);
    wreg(4'hA, 8'hF0);
    wreg(4'hB, 8'h5A);
    chk(oe, 8'hF0);
    chk(po, 8'h50);
    pins(8'h0C);
    rchk(4'hB, 8'h5C);
    wreg(4'hA, 8'h00);
    wreg(4'hC, 8'h01);
    rchk(4'hB, 8'h0C);
    pins(8'h0D);
    chk({7'h0, irq}, 8'h01);
    pins(8'h0C);
    chk({7'h0, irq}, 8'h00);
    wreg(4'hC, 8'h02);
    pins(8'h0D);
    chk({7'h0, irq}, 8'h00);
    pins(8'h0C);
    wreg(4'hC, 8'h01);
    wreg(4'hE, 8'h01);
    pins(8'h0D);
    pins(8'h0C);
    chk({7'h0, irq}, 8'h01);
    rchk(4'hB, 8'h0D);
    wreg(4'hE, 8'h04);
    rchk(4'hE, 8'h04);
    @(posedge clk);
    tr2 <= 1'b1;
    pins(8'h05);
    chk({7'h0, irq}, 8'h00);
    chk({5'h0, r2, c2, s2}, 8'h03);
    chk({oe[3:0], 3'h0, po[1]}, 8'h21);
    wreg(4'hA, 8'hF0);
    wreg(4'hE, 8'h08);
    chk({7'h0, sr}, 8'h01);
    repeat (4) @(posedge clk);
    #1;
    chk({7'h0, sr}, 8'h00);
    rchk(4'hE, 8'h00);
    rchk(4'hA, 8'h00);
    rchk(4'hC, 8'h00);
    @(posedge clk);
    tr1 <= 1'b1;
    wreg(4'hE, 8'h02);
    pins(8'h90);
    chk({6'h0, m1, m2}, 8'h02);
    chk({5'h0, r1, c1, s1}, 8'h05);
    chk({oe[7:4], 3'h0, po[5]}, 8'h21);
    finish_test();
  end
endmodule : tb_bridge_gpio_modem_pin_port
